//--- design/apm1_addr_decode.sv
// address window decoder for one access side of the pm1 event block
// assumes base plus span does not wrap past the top of the space
`timescale 1ns/1ps
module apm1_addr_decode #(
   parameter int AW = 16
) (
   // access
   input  wire logic [AW-1:0] addr,
   input  wire logic [AW-1:0] base,
   input  wire logic [AW-1:0] span,
   // result
   output logic               hit,
   output logic [4:0]         offset
);

   logic [AW-1:0] delta;

   assign delta  = addr - base;
   // the lower bound check keeps an address below base from wrapping into range
   assign hit    = (addr >= base) && (delta < span);
   assign offset = delta[4:0];

endmodule : apm1_addr_decode

//--- design/apm1_consts.svh
// offsets, field positions, reset values and address windows of the pm1 event block
// assumes inclusion by the register bank and by the bench
`ifndef APM1_CONSTS_SVH
`define APM1_CONSTS_SVH

// register offsets, the same for host and ec
`define APM1_OFF_STATUS_LOW   5'h00
`define APM1_OFF_EVENT_STATUS 5'h01
`define APM1_OFF_ENABLE_LOW   5'h02
`define APM1_OFF_EVENT_ENABLE 5'h03
`define APM1_OFF_CONTROL_LOW  5'h04
`define APM1_OFF_CONTROL_HIGH 5'h05
`define APM1_OFF_PM2_LOW      5'h06
`define APM1_OFF_PM2_HIGH     5'h07
`define APM1_OFF_CTRL_SCI     5'h10

// address windows
`define APM1_EC_BASE   32'h000F_1400
`define APM1_EC_SPAN   32'h0000_0020
`define APM1_HOST_SPAN 16'h0008

// event status fields
`define APM1_BIT_WAKE     7
`define APM1_BIT_OVERRIDE 3
`define APM1_BIT_ALARM    2
`define APM1_BIT_SLEEP    1
`define APM1_BIT_POWER    0
`define APM1_STATUS_MASK  8'h8F

// control high fields
`define APM1_BIT_TRIGGER  5
`define APM1_TYPE_MSB     4
`define APM1_TYPE_LSB     2
`define APM1_BIT_OVR_EN   1

// controller sci status fields
`define APM1_BIT_CTRL_SCI 0

// reset values
`define APM1_RST_STATUS   8'h00
`define APM1_RST_ENABLE   3'h0
`define APM1_RST_TYPE     3'h0
`define APM1_RST_CTRL_SCI 8'h00
`define APM1_RST_DATA     8'h00

`endif

//--- design/apm1_pkg.sv
// types shared by the pm1 event block modules
// assumes apm1_consts.svh sits beside it
package apm1_pkg;

   // host i/o cycle, already taken off the lpc or espi link
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } apm1_host_req_t;

   // ec access on the internal 32-bit space
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [31:0] addr;
      logic [7:0]  wdata;
   } apm1_ec_req_t;

   // answer to either side
   typedef struct packed {
      logic       ack;
      logic [7:0] rdata;
   } apm1_ans_t;

   // sleep control seen by the ec firmware
   typedef struct packed {
      logic [2:0] sleep_type;
      logic       sleep_trigger;
      logic       override_enable;
   } apm1_ctl_t;

endpackage : apm1_pkg

//--- design/apm1_regs.sv
// pm1 event register bank shared by host i/o cycles and the embedded controller
// assumes host cycles arrive already decoded from lpc or espi, one clock domain,
// and the rtc alarm input coming from logic on the same clock
//
// Notes on behaviour
// - ec firmware sets the sleep button flag to report a sleep button event.
// - an rtc alarm event sets the alarm flag.
// - a pending flag with its enable set drives an sci event to host.
// - ec reads and writes status flags but only reads enable bits.
// - host decodes at programmable i/o base, ec at fixed internal base.
// - host reaches every register except the controller sci status at 10h.
// - byte registers at 00h to 07h, controller sci status at 10h.
// - wake flag bit 7; ec sets or clears, host one clears.
// - override flag bit 3; ec sets or clears it.
// - alarm flag bit 2; ec writes set or clear it.
// - sleep button flag bit 1; ec writes set or clear it.
// - power button flag bit 0; ec writes set or clear it.
// - ec status writes store the written value directly.
// - host status writes clear ones and leave zeros unchanged.
// - all status flags reset to zero.
// - alarm enable bit 2, host read and write, resets to zero.
// - sleep button enable bit 1, host read and write, resets zero.
// - power button enable bit 0, host read and write, resets zero.
// - ec writes to enable bits are ignored.
// - sci asserted low when power, sleep or alarm flag meets its enable.
// - sci asserted low when controller sci request bit is one.
// - host writes to control high, enable or status pulse ec interrupts.
// - sleep trigger: host reads zero, sets by one; ec reads, clears by one.
`timescale 1ns/1ps
`include "apm1_consts.svh"
module apm1_regs (
   // clock and reset
   input  wire logic                     clock,
   input  wire logic                     reset_n,
   // host i/o side
   input  wire logic [15:0]              host_base,
   input  wire apm1_pkg::apm1_host_req_t host_req,
   output apm1_pkg::apm1_ans_t           host_ans,
   // ec side
   input  wire apm1_pkg::apm1_ec_req_t   ec_req,
   output apm1_pkg::apm1_ans_t           ec_ans,
   // events
   input  wire logic                     rtc_alarm,
   // to host
   output logic                          sci_out_n,
   // to ec
   output logic                          control_write_irq,
   output logic                          enable_write_irq,
   output logic                          status_write_irq,
   output apm1_pkg::apm1_ctl_t           ctl
);

   logic       host_hit;
   logic [4:0] host_off;
   logic       ec_hit;
   logic [4:0] ec_off;
   logic       host_wr;
   logic       host_rd;
   logic       ec_wr;
   logic       ec_rd;
   logic       host_wr_sts;
   logic       host_wr_en;
   logic       host_wr_ctl;
   logic       ec_wr_sts;
   logic       ec_wr_ctl;
   logic       ec_wr_sci;
   logic [7:0] status;
   logic [7:0] next_status;
   logic [2:0] enable;
   logic [2:0] sleep_type;
   logic       override_enable;
   logic       sleep_trigger;
   logic       next_sleep_trigger;
   logic [7:0] controller_sci_status_reg;
   logic [2:0] pending;
   logic       sci_request;

   apm1_addr_decode #(.AW(16)) u_host_decode (
      .addr   (host_req.addr),
      .base   (host_base),
      .span   (`APM1_HOST_SPAN),
      .hit    (host_hit),
      .offset (host_off)
   );

   apm1_addr_decode #(.AW(32)) u_ec_decode (
      .addr   (ec_req.addr),
      .base   (`APM1_EC_BASE),
      .span   (`APM1_EC_SPAN),
      .hit    (ec_hit),
      .offset (ec_off)
   );

   // the host window ends at 07h, so 10h is never claimed from the host side
   assign host_wr = host_req.valid && host_req.write && host_hit;
   assign host_rd = host_req.valid && !host_req.write && host_hit;
   assign ec_wr   = ec_req.valid && ec_req.write && ec_hit;
   assign ec_rd   = ec_req.valid && !ec_req.write && ec_hit;

   assign host_wr_sts = host_wr && (host_off == `APM1_OFF_EVENT_STATUS);
   assign host_wr_en  = host_wr && (host_off == `APM1_OFF_EVENT_ENABLE);
   assign host_wr_ctl = host_wr && (host_off == `APM1_OFF_CONTROL_HIGH);
   assign ec_wr_sts   = ec_wr && (ec_off == `APM1_OFF_EVENT_STATUS);
   assign ec_wr_ctl   = ec_wr && (ec_off == `APM1_OFF_CONTROL_HIGH);
   assign ec_wr_sci   = ec_wr && (ec_off == `APM1_OFF_CTRL_SCI);

   // read view of one register; the host sees the trigger as zero
   function automatic logic [7:0] read_reg(input logic [4:0] off, input logic from_host);
      logic [7:0] value;
      value = `APM1_RST_DATA;
      case (off)
         `APM1_OFF_EVENT_STATUS: begin
            value = status & `APM1_STATUS_MASK;
         end
         `APM1_OFF_EVENT_ENABLE: begin
            value[2:0] = enable;
         end
         `APM1_OFF_CONTROL_HIGH: begin
            value[`APM1_TYPE_MSB:`APM1_TYPE_LSB] = sleep_type;
            value[`APM1_BIT_OVR_EN]              = override_enable;
            value[`APM1_BIT_TRIGGER]             = sleep_trigger && !from_host;
         end
         `APM1_OFF_CTRL_SCI: begin
            value = from_host ? `APM1_RST_DATA : controller_sci_status_reg;
         end
         default: begin
            value = `APM1_RST_DATA;
         end
      endcase
      return value;
   endfunction : read_reg

   // status flags: host clears first, a whole ec write then overrides, alarm last
   always_comb begin
      next_status = status;
      if (host_wr_sts) begin
         next_status = status & ~host_req.wdata;
      end
      if (ec_wr_sts) begin
         next_status = ec_req.wdata;
      end
      if (rtc_alarm) begin
         next_status[`APM1_BIT_ALARM] = 1'b1;
      end
      next_status = next_status & `APM1_STATUS_MASK;
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         status <= `APM1_RST_STATUS;
      end else begin
         status <= next_status;
      end
   end

   // enables follow host writes only; ec writes to them fall on the floor
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         enable <= `APM1_RST_ENABLE;
      end else if (host_wr_en) begin
         enable <= host_req.wdata[2:0];
      end
   end

   // sleep type and override enable are host owned, ec only reads them
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         sleep_type      <= `APM1_RST_TYPE;
         override_enable <= 1'b0;
      end else if (host_wr_ctl) begin
         sleep_type      <= host_req.wdata[`APM1_TYPE_MSB:`APM1_TYPE_LSB];
         override_enable <= host_req.wdata[`APM1_BIT_OVR_EN];
      end
   end

   // a host set arriving with an ec clear wins so no sleep request is lost
   always_comb begin
      next_sleep_trigger = sleep_trigger;
      if (ec_wr_ctl && ec_req.wdata[`APM1_BIT_TRIGGER]) begin
         next_sleep_trigger = 1'b0;
      end
      if (host_wr_ctl && host_req.wdata[`APM1_BIT_TRIGGER]) begin
         next_sleep_trigger = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         sleep_trigger <= 1'b0;
      end else begin
         sleep_trigger <= next_sleep_trigger;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         controller_sci_status_reg <= `APM1_RST_CTRL_SCI;
      end else if (ec_wr_sci) begin
         controller_sci_status_reg <= ec_req.wdata;
      end
   end

   // status bits 0..2 line up with enable bits 0..2
   for (genvar i = 0; i < 3; i++) begin : g_pending
      assign pending[i] = status[i] & enable[i];
   end

   assign sci_request = (|pending) || controller_sci_status_reg[`APM1_BIT_CTRL_SCI];

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         sci_out_n <= 1'b1;
      end else begin
         sci_out_n <= !sci_request;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         control_write_irq <= 1'b0;
         enable_write_irq  <= 1'b0;
         status_write_irq  <= 1'b0;
      end else begin
         control_write_irq <= host_wr_ctl;
         enable_write_irq  <= host_wr_en;
         status_write_irq  <= host_wr_sts;
      end
   end

   // answers come one cycle after the request and show pre-write contents
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         host_ans <= '0;
      end else begin
         host_ans.ack   <= host_req.valid && host_hit;
         host_ans.rdata <= host_rd ? read_reg(host_off, 1'b1) : `APM1_RST_DATA;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ec_ans <= '0;
      end else begin
         ec_ans.ack   <= ec_req.valid && ec_hit;
         ec_ans.rdata <= ec_rd ? read_reg(ec_off, 1'b0) : `APM1_RST_DATA;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ctl <= '0;
      end else begin
         ctl.sleep_type      <= sleep_type;
         ctl.sleep_trigger   <= sleep_trigger;
         ctl.override_enable <= override_enable;
      end
   end

   property p_alarm_sets;
      @(posedge clock) disable iff (!reset_n)
      rtc_alarm |=> status[`APM1_BIT_ALARM];
   endproperty
   a_alarm_sets: assert property (p_alarm_sets)
      else $error("alarm event did not set alarm flag");

   property p_ec_sleep_set;
      @(posedge clock) disable iff (!reset_n)
      ec_wr_sts && ec_req.wdata[`APM1_BIT_SLEEP] |=> status[`APM1_BIT_SLEEP] ##1 !sci_out_n
         || !enable[1];
   endproperty
   a_ec_sleep_set: assert property (p_ec_sleep_set)
      else $error("ec sleep event not recorded or not signalled");

   property p_ec_direct;
      @(posedge clock) disable iff (!reset_n)
      ec_wr_sts && !rtc_alarm |=> status == ($past(ec_req.wdata) & `APM1_STATUS_MASK);
   endproperty
   a_ec_direct: assert property (p_ec_direct)
      else $error("ec status write not stored directly");

   property p_host_clear;
      @(posedge clock) disable iff (!reset_n)
      host_wr_sts && !ec_wr_sts && !rtc_alarm
         |=> status == ($past(status) & ~$past(host_req.wdata));
   endproperty
   a_host_clear: assert property (p_host_clear)
      else $error("host write-one clear wrong");

   property p_ec_wins;
      @(posedge clock) disable iff (!reset_n)
      host_wr_sts && ec_wr_sts && host_req.wdata[`APM1_BIT_WAKE] && ec_req.wdata[`APM1_BIT_WAKE]
         |=> status[`APM1_BIT_WAKE];
   endproperty
   a_ec_wins: assert property (p_ec_wins)
      else $error("host clear beat ec set");

   property p_sci_follows;
      @(posedge clock) disable iff (!reset_n)
      ##1 sci_out_n == !($past(|(status[2:0] & enable))
         || $past(controller_sci_status_reg[`APM1_BIT_CTRL_SCI]));
   endproperty
   a_sci_follows: assert property (p_sci_follows)
      else $error("sci output disagrees with flags and enables");

   property p_ec_enable_ignored;
      @(posedge clock) disable iff (!reset_n)
      ec_wr && ec_off == `APM1_OFF_EVENT_ENABLE && !host_wr_en |=> $stable(enable);
   endproperty
   a_ec_enable_ignored: assert property (p_ec_enable_ignored)
      else $error("ec write changed an enable bit");

   property p_irq_pulse;
      @(posedge clock) disable iff (!reset_n)
      host_wr_sts |=> status_write_irq && !enable_write_irq && !control_write_irq;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse)
      else $error("status write interrupt missing");

   property p_host_no_sci_reg;
      @(posedge clock) disable iff (!reset_n)
      host_req.valid && host_req.addr == host_base + 16'h0010 |=> !host_ans.ack;
   endproperty
   a_host_no_sci_reg: assert property (p_host_no_sci_reg)
      else $error("host claimed the ec only register");

   property p_trigger_hidden;
      @(posedge clock) disable iff (!reset_n)
      host_rd && host_off == `APM1_OFF_CONTROL_HIGH |=> !host_ans.rdata[`APM1_BIT_TRIGGER];
   endproperty
   a_trigger_hidden: assert property (p_trigger_hidden)
      else $error("host read saw the sleep trigger");

   property p_reserved_zero;
      @(posedge clock) disable iff (!reset_n)
      ec_rd && ec_off == `APM1_OFF_STATUS_LOW |=> ec_ans.ack && ec_ans.rdata == 8'h00;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved register read not zero");

   property p_ec_read_status;
      @(posedge clock) disable iff (!reset_n)
      ec_req.valid && !ec_req.write && ec_req.addr == `APM1_EC_BASE + 32'h0000_0001
         |=> ec_ans.ack && ec_ans.rdata == $past(status);
   endproperty
   a_ec_read_status: assert property (p_ec_read_status)
      else $error("ec read of event status wrong");

endmodule : apm1_regs

//--- verification/apm1_host_model.sv
// host chipset model: issues decoded i/o cycles into the pm1 event block
// assumes the bench calls io() just after a rising edge of clock
`timescale 1ns/1ps
module apm1_host_model (
   // base and clock
   input  wire logic                [15:0] host_base,
   input  wire logic                       clock,
   // i/o cycle toward the block
   output apm1_pkg::apm1_host_req_t        host_req
);
   initial host_req = '0;

   // one cycle, then an idle cycle, so valid never falls and rises in one step
   task automatic io(input logic w, input logic [4:0] off, input logic [7:0] d);
      host_req = '{valid: 1'b1, write: w, addr: host_base + {11'h000, off}, wdata: d};
      @(posedge clock);
      #1 host_req.valid = 1'b0;
      @(posedge clock);
      #1;
   endtask : io
endmodule : apm1_host_model

//--- verification/apm1_regs_tb.sv
// self-checking bench of the pm1 event register bank, host and ec sides
// assumes apm1_consts.svh on the include path and the package compiled first
`timescale 1ns/1ps
`include "apm1_consts.svh"
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin err_count++; \
   $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module apm1_regs_tb;
   logic                     clock     = 1'b0;
   logic                     reset_n   = 1'b0;
   logic [15:0]              host_base = 16'h0C80;
   logic                     rtc_alarm = 1'b0;
   apm1_pkg::apm1_host_req_t host_req;
   apm1_pkg::apm1_ec_req_t   ec_req    = '0;
   apm1_pkg::apm1_ans_t      host_ans;
   apm1_pkg::apm1_ans_t      ec_ans;
   apm1_pkg::apm1_ctl_t      ctl;
   logic                     sci_out_n;
   logic                     control_write_irq;
   logic                     enable_write_irq;
   logic                     status_write_irq;
   int                       err_count = 0;
   int                       cmp_count = 0;
   int                       cycles    = 0;
   int                       n_ctl     = 0;
   int                       n_en      = 0;
   int                       n_sts     = 0;
   logic [7:0]               host_q[$];
   logic [7:0]               ec_q[$];
   logic [31:0]              seed      = 32'h3A1C;
   logic [7:0]               r;
   logic [7:0]               w;
   // popped once per answer, so a mismatch report cannot drain a second note
   logic [7:0]               note;

   always #2 clock = ~clock;

   apm1_host_model u_host (.host_base(host_base), .clock(clock), .host_req(host_req));

   apm1_regs u_dut (
      .clock(clock), .reset_n(reset_n), .host_base(host_base), .host_req(host_req),
      .host_ans(host_ans), .ec_req(ec_req), .ec_ans(ec_ans), .rtc_alarm(rtc_alarm),
      .sci_out_n(sci_out_n), .control_write_irq(control_write_irq),
      .enable_write_irq(enable_write_irq), .status_write_irq(status_write_irq), .ctl(ctl)
   );

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up

   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction : rnd

   // offsets past the ec span expect no answer, so nothing is queued for them
   task automatic ec_io(input logic w, input logic [8:0] off, input logic [7:0] d,
                        input logic [7:0] exp);
      if (off < 9'h020) ec_q.push_back(exp);
      ec_req = '{valid: 1'b1, write: w, addr: `APM1_EC_BASE + {23'h000000, off}, wdata: d};
      @(posedge clock);
      #1 ec_req.valid = 1'b0;
      @(posedge clock);
      #1;
   endtask : ec_io

   task automatic host_io(input logic w, input logic [4:0] off, input logic [7:0] d,
                          input logic [7:0] exp);
      host_q.push_back(exp);
      u_host.io(w, off, d);
   endtask : host_io

   // sci follows a register change one cycle after the answer
   task automatic sci_is(input logic exp);
      @(posedge clock);
      #1;
      `CHK(sci_out_n, exp)
   endtask : sci_is

   // every answer is matched against the oldest note of its side
   always @(negedge clock) begin
      if (host_ans.ack === 1'b1) begin
         if (host_q.size() == 0) `CHK(1'b1, 1'b0)
         else begin
            note = host_q.pop_front();
            `CHK(host_ans.rdata, note)
         end
      end
      if (ec_ans.ack === 1'b1) begin
         if (ec_q.size() == 0) `CHK(1'b1, 1'b0)
         else begin
            note = ec_q.pop_front();
            `CHK(ec_ans.rdata, note)
         end
      end
   end

   always @(posedge clock) begin
      if (control_write_irq === 1'b1) n_ctl++;
      if (enable_write_irq === 1'b1) n_en++;
      if (status_write_irq === 1'b1) n_sts++;
      cycles++;
      if (cycles == 6000) begin
         err_count++;
         $display("wrong value at %0t: run did not finish", $time);
         wrap_up();
      end
   end

   initial begin
      repeat (20) @(posedge clock);
      #1 reset_n = 1'b1;
      `CHK(sci_out_n, 1'b1)
      for (int i = 0; i < 8; i++) ec_io(1'b0, 9'(i), 8'h00, 8'h00);
      ec_io(1'b0, `APM1_OFF_CTRL_SCI, 8'h00, 8'h00);
      repeat (4) begin
         r = rnd();
         w = rnd();
         ec_io(1'b1, `APM1_OFF_EVENT_STATUS, r, 8'h00);
         ec_io(1'b0, `APM1_OFF_EVENT_STATUS, 8'h00, r & 8'h8F);
         host_io(1'b1, `APM1_OFF_EVENT_STATUS, w, 8'h00);
         host_io(1'b0, `APM1_OFF_EVENT_STATUS, 8'h00, r & 8'h8F & ~w);
      end
      host_io(1'b1, `APM1_OFF_EVENT_ENABLE, 8'hFF, 8'h00);
      ec_io(1'b1, `APM1_OFF_EVENT_ENABLE, 8'h00, 8'h00);
      ec_io(1'b0, `APM1_OFF_EVENT_ENABLE, 8'h00, 8'h07);
      host_io(1'b0, `APM1_OFF_EVENT_ENABLE, 8'h00, 8'h07);
      ec_io(1'b1, `APM1_OFF_EVENT_STATUS, 8'h00, 8'h00);
      for (int i = 0; i < 3; i++) begin
         ec_io(1'b1, `APM1_OFF_EVENT_STATUS, 8'(1 << i), 8'h00);
         sci_is(1'b0);
         host_io(1'b1, `APM1_OFF_EVENT_ENABLE, ~8'(1 << i), 8'h00);
         sci_is(1'b1);
         host_io(1'b1, `APM1_OFF_EVENT_ENABLE, 8'h07, 8'h00);
         host_io(1'b1, `APM1_OFF_EVENT_STATUS, 8'(1 << i), 8'h00);
         sci_is(1'b1);
      end
      ec_io(1'b1, `APM1_OFF_EVENT_STATUS, 8'h88, 8'h00);
      sci_is(1'b1);
      host_io(1'b1, `APM1_OFF_EVENT_STATUS, 8'h88, 8'h00);
      ec_io(1'b0, `APM1_OFF_EVENT_STATUS, 8'h00, 8'h00);
      host_io(1'b1, `APM1_OFF_EVENT_ENABLE, 8'h00, 8'h00);
      ec_io(1'b1, `APM1_OFF_EVENT_STATUS, 8'h07, 8'h00);
      sci_is(1'b1);
      ec_io(1'b1, `APM1_OFF_CTRL_SCI, 8'h81, 8'h00);
      sci_is(1'b0);
      ec_io(1'b0, `APM1_OFF_CTRL_SCI, 8'h00, 8'h81);
      u_host.io(1'b0, 5'h10, 8'h00);
      ec_io(1'b1, `APM1_OFF_CTRL_SCI, 8'h00, 8'h00);
      sci_is(1'b1);
      ec_io(1'b1, `APM1_OFF_EVENT_STATUS, 8'h00, 8'h00);
      rtc_alarm = 1'b1;
      @(posedge clock);
      #1 rtc_alarm = 1'b0;
      ec_io(1'b0, `APM1_OFF_EVENT_STATUS, 8'h00, 8'h04);
      ec_io(1'b0, 9'h100, 8'h00, 8'h00);
      host_io(1'b1, `APM1_OFF_CONTROL_HIGH, 8'h3E, 8'h00);
      host_io(1'b0, `APM1_OFF_CONTROL_HIGH, 8'h00, 8'h1E);
      ec_io(1'b0, `APM1_OFF_CONTROL_HIGH, 8'h00, 8'h3E);
      `CHK(ctl.sleep_trigger, 1'b1)
      ec_io(1'b1, `APM1_OFF_CONTROL_HIGH, 8'h20, 8'h00);
      ec_io(1'b0, `APM1_OFF_CONTROL_HIGH, 8'h00, 8'h1E);
      `CHK(ctl, 5'h1D)
      ec_io(1'b1, `APM1_OFF_EVENT_STATUS, 8'h01, 8'h00);
      // wake and power set by the ec while the host clears both in the same cycle
      fork
         host_io(1'b1, `APM1_OFF_EVENT_STATUS, 8'h81, 8'h00);
         ec_io(1'b1, `APM1_OFF_EVENT_STATUS, 8'h81, 8'h00);
      join
      ec_io(1'b0, `APM1_OFF_EVENT_STATUS, 8'h00, 8'h81);
      `CHK(n_ctl, 1)
      `CHK(n_en, 8)
      `CHK(n_sts, 9)
      reset_n = 1'b0;
      @(posedge clock);
      #1 reset_n = 1'b1;
      ec_io(1'b0, `APM1_OFF_EVENT_STATUS, 8'h00, 8'h00);
      // move the host window so the programmable base is exercised
      host_base = 16'h0A40;
      host_io(1'b0, `APM1_OFF_EVENT_ENABLE, 8'h00, 8'h00);
      repeat (2) @(posedge clock);
      wrap_up();
   end
endmodule : apm1_regs_tb
